// *** hdl/lamp_shutdown_defs.svh ***
`ifndef LAMP_SHUTDOWN_DEFS_SVH
`define LAMP_SHUTDOWN_DEFS_SVH

// register selects on the internal register port
`define REG_SEL_MODE       3'h0
`define REG_SEL_STATUS     3'h1
`define REG_SEL_MAKER      3'h2
`define REG_SEL_PART       3'h3
`define REG_SEL_REVISION   3'h4

// shutdown-mode field bit positions and reset
`define MODE_BIT_LOW_OFF   0
`define MODE_BIT_HIGH_OFF  1
`define MODE_BIT_FORCE     2
`define MODE_RESET         3'h1

// status field bit positions and reset
`define STAT_BIT_NO_OC     0
`define STAT_BIT_LAMP      1
`define STATUS_RESET       2'h3

// identification values, arbitrary
`define MAKER_CODE         8'h5a
`define PART_CODE          8'h3c
`define REVISION_CODE      8'h01

// lamp-out timeout
`define CLK_HZ             100000000
`define LAMP_OUT_SEC       2
`define LAMP_OUT_CYCLES    (`CLK_HZ * `LAMP_OUT_SEC)

`endif

// *** hdl/lamp_shutdown_pkg.sv ***
package lamp_shutdown_pkg;
  typedef logic [2:0] mode_field_t;
  typedef logic [1:0] status_field_t;
  typedef enum logic [1:0] {
    LAMP_RUN   = 2'b00,
    LAMP_OFF   = 2'b01,
    LAMP_FAULT = 2'b11
  } lamp_state_t;
endpackage

// *** hdl/pin_sync_if.sv ***
`timescale 1ns/1ps
interface pin_sync_if;
  logic level;
  logic edge_any;
  modport src (output level, output edge_any);
  modport dst (input level, input edge_any);
endinterface

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk_sys,  // system clock
  input  wire logic reset,    // async reset, active high
  input  wire logic pin_in,   // raw pin
  pin_sync_if.src   sync      // synchronised level and edge
);
  logic meta_r;
  logic stable_r;
  logic prev_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_r   <= 1'b0;
      stable_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      meta_r   <= pin_in;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

  assign sync.level    = stable_r;
  assign sync.edge_any = stable_r ^ prev_r;
endmodule

// *** hdl/lamp_shutdown_status_regs.sv ***
// Operation
// - run only if force-off and selected bit clear
// - status field ignores host writes
// - lamp flag powers up one, cleared on lamp-out
// - lamp flag stays cleared until re-armed
// - lamp flag set again by shutdown or by a pin toggle
// - overcurrent in last period reads zero
// - clean last period reads one
// - fixed read-only identification registers
// - writes to identification registers ignored
// - cleared lamp flag forces lamp off
// - lamp flag clears after two seconds undetected
// - mode field powers up as 001
`timescale 1ns/1ps
`include "lamp_shutdown_defs.svh"
module lamp_shutdown_status_regs
  import lamp_shutdown_pkg::*;
#(
  parameter int unsigned LAMP_OUT_CYCLES = `LAMP_OUT_CYCLES
) (
  input  wire logic       clk_sys,              // system clock
  input  wire logic       reset,                // async reset, active high
  input  wire logic       shutdown_suspend_pin, // shutdown/suspend pin
  input  wire logic       lamp_current_feedback,// current above threshold
  input  wire logic       overcurrent,          // overcurrent detected
  input  wire logic       pwm_period_start,     // dimming period boundary
  input  wire logic       reg_wr,               // register write strobe
  input  wire logic [2:0] reg_sel,              // register select
  input  wire logic [7:0] reg_wdata,            // write data
  output logic      [7:0] reg_rdata,            // read data
  output logic            lamp_run,             // lamp may operate
  output logic      [2:0] shutdown_mode_field,  // mode field
  output logic      [1:0] lamp_fault_status     // status field
);
  pin_sync_if pin_s ();

  pin_sync u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_in  (shutdown_suspend_pin),
    .sync    (pin_s)
  );

  mode_field_t   mode_r;
  mode_field_t   mode_nxt;
  logic          lamp_present_flag_r;
  logic          lamp_present_flag_nxt;
  logic          no_overcurrent_flag_r;
  logic          no_overcurrent_flag_nxt;
  logic          oc_seen_r;
  logic          oc_seen_nxt;
  logic [31:0]   dark_cnt_r;
  logic [31:0]   dark_cnt_nxt;
  lamp_state_t   state_r;
  lamp_state_t   state_nxt;
  logic [7:0]    rdata_nxt;
  logic          lamp_run_nxt;
  status_field_t status_word;

  // last count of the lamp-out timer, cut to the counter's width
  localparam logic [31:0] DARK_LAST = 32'(LAMP_OUT_CYCLES - 1);

  // the pin level picks which mode bit may shut the lamp off
  function automatic logic mode_shuts_off(input mode_field_t m,
                                          input logic        pin_high);
    logic sel_bit;
    sel_bit = pin_high ? m[`MODE_BIT_HIGH_OFF] : m[`MODE_BIT_LOW_OFF];
    return m[`MODE_BIT_FORCE] | sel_bit;
  endfunction

  wire mode_wr   = reg_wr && (reg_sel == `REG_SEL_MODE);
  wire mode_off  = mode_shuts_off(mode_r, pin_s.level);
  // writing a shut-off mode or toggling the pin re-arms the flag
  wire rearm     = mode_off | pin_s.edge_any;
  wire run_ok    = !mode_off && lamp_present_flag_r;
  wire dark_done = (dark_cnt_r >= DARK_LAST);
  wire lamp_out  = run_ok && dark_done && !lamp_current_feedback;

  always_comb begin
    mode_nxt = mode_r;
    if (mode_wr) begin
      mode_nxt = reg_wdata[2:0];
    end
  end

  // lamp-out timer runs only while the lamp is driven
  always_comb begin
    dark_cnt_nxt = dark_cnt_r;
    if (!run_ok || lamp_current_feedback) begin
      dark_cnt_nxt = 32'h0;
    end else if (!dark_done) begin
      dark_cnt_nxt = dark_cnt_r + 32'h1;
    end
  end

  // re-arm wins over a fresh detection in the same cycle
  always_comb begin
    lamp_present_flag_nxt = lamp_present_flag_r;
    if (rearm) begin
      lamp_present_flag_nxt = 1'b1;
    end else if (lamp_out) begin
      lamp_present_flag_nxt = 1'b0;
    end
  end

  // the boundary cycle itself still counts for the closing period
  always_comb begin
    oc_seen_nxt             = oc_seen_r | overcurrent;
    no_overcurrent_flag_nxt = no_overcurrent_flag_r;
    if (pwm_period_start) begin
      no_overcurrent_flag_nxt = !(oc_seen_r | overcurrent);
      oc_seen_nxt             = 1'b0;
    end
  end

  // gray path: run -> off -> fault, and back through off
  always_comb begin
    case (state_r)
      LAMP_RUN: begin
        if (run_ok) begin
          state_nxt = LAMP_RUN;
        end else begin
          state_nxt = LAMP_OFF;
        end
      end
      LAMP_OFF: begin
        if (run_ok) begin
          state_nxt = LAMP_RUN;
        end else if (lamp_present_flag_r) begin
          state_nxt = LAMP_OFF;
        end else begin
          state_nxt = LAMP_FAULT;
        end
      end
      LAMP_FAULT: begin
        if (lamp_present_flag_r) begin
          state_nxt = LAMP_OFF;
        end else begin
          state_nxt = LAMP_FAULT;
        end
      end
      default: begin
        state_nxt = LAMP_OFF;
      end
    endcase
  end

  // a recovered fault waits one cycle in off before the lamp starts
  assign lamp_run_nxt = run_ok && (state_r != LAMP_FAULT);

  // one status word feeds both the read path and the status port
  assign status_word = {lamp_present_flag_r, no_overcurrent_flag_r};

  always_comb begin
    case (reg_sel)
      `REG_SEL_MODE:     rdata_nxt = {5'h0, mode_r};
      `REG_SEL_STATUS:   rdata_nxt = {6'h0, status_word};
      `REG_SEL_MAKER:    rdata_nxt = `MAKER_CODE;
      `REG_SEL_PART:     rdata_nxt = `PART_CODE;
      `REG_SEL_REVISION: rdata_nxt = `REVISION_CODE;
      default:           rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_r <= `MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dark_cnt_r <= 32'h0;
    end else begin
      dark_cnt_r <= dark_cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lamp_present_flag_r <= 1'b1;
    end else begin
      lamp_present_flag_r <= lamp_present_flag_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oc_seen_r             <= 1'b0;
      no_overcurrent_flag_r <= 1'b1;
    end else begin
      oc_seen_r             <= oc_seen_nxt;
      no_overcurrent_flag_r <= no_overcurrent_flag_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= LAMP_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // status and id selects decode no write path at all
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      lamp_run  <= 1'b0;
    end else begin
      reg_rdata <= rdata_nxt;
      lamp_run  <= lamp_run_nxt;
    end
  end

  // mode field is visible to the power stage without a bus read
  assign shutdown_mode_field = mode_r;
  assign lamp_fault_status   = status_word;
endmodule

// *** test/lamp_shutdown_status_regs_properties.sv ***
`timescale 1ns/1ps
`include "lamp_shutdown_defs.svh"
module lamp_shutdown_props #(
  parameter int unsigned LAMP_OUT_CYCLES = 20
) (
  input wire logic       clk_sys,               // clock
  input wire logic       reset,                 // reset
  input wire logic       lamp_current_feedback, // lamp current
  input wire logic       overcurrent,           // overcurrent
  input wire logic       pwm_period_start,      // period edge
  input wire logic [2:0] reg_sel,               // select
  input wire logic [7:0] reg_rdata,             // read data
  input wire logic       lamp_run,              // lamp on
  input wire logic [2:0] shutdown_mode_field,   // mode
  input wire logic [1:0] lamp_fault_status      // status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [31:0] dark_r;
  logic        oc_r;
  // counts from the first cycle lamp_run shows high with no current
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dark_r <= 32'h0;
      oc_r   <= 1'b0;
    end else begin
      dark_r <= (lamp_run && !lamp_current_feedback && lamp_fault_status[1])
                ? dark_r + 32'h1 : 32'h0;
      oc_r   <= !pwm_period_start && (oc_r || overcurrent);
    end
  end
  sequence s_flag_low;
    !lamp_fault_status[1] ##1 !lamp_fault_status[1];
  endsequence
  sequence s_forced;
    shutdown_mode_field[2] ##1 shutdown_mode_field[2];
  endsequence
  a_force_off: assert property (
    shutdown_mode_field[2] |=> !lamp_run) else $error("run while forced");
  a_flag_blocks: assert property (
    s_flag_low |-> !lamp_run) else $error("run with flag clear");
  a_mode_rearm: assert property (
    s_forced |=> lamp_fault_status[1]) else $error("flag not re-armed");
  a_lamp_out: assert property (
    dark_r == LAMP_OUT_CYCLES - 1 |-> !lamp_fault_status[1])
    else $error("lamp-out missed");
  a_oc_seen: assert property (
    pwm_period_start && overcurrent |=> !lamp_fault_status[0])
    else $error("overcurrent not shown");
  a_oc_clean: assert property (
    pwm_period_start && !overcurrent && !oc_r |=> lamp_fault_status[0])
    else $error("clean period not shown");
  a_oc_hold: assert property (
    !pwm_period_start |=> $stable(lamp_fault_status[0]))
    else $error("status moved mid-period");
  a_maker_read: assert property (
    reg_sel == `REG_SEL_MAKER |=> reg_rdata == `MAKER_CODE)
    else $error("maker code wrong");
endmodule

bind lamp_shutdown_status_regs lamp_shutdown_props #(
  .LAMP_OUT_CYCLES(LAMP_OUT_CYCLES)) u_props (.*);

// *** test/lamp_stage_model.sv ***
`timescale 1ns/1ps
module lamp_stage_model (
  input  wire logic clk_sys,              // clock
  input  wire logic reset,                // reset
  input  wire logic lamp_run,             // drive on
  input  wire logic connected,            // lamp fitted
  output logic      lamp_current_feedback // current seen
);
  // no lamp fitted means no current, however hard it is driven
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lamp_current_feedback <= 1'b0;
    end else begin
      lamp_current_feedback <= lamp_run && connected;
    end
  end
endmodule

// *** test/lamp_shutdown_status_regs_tb.sv ***
`timescale 1ns/1ps
`include "lamp_shutdown_defs.svh"
module lamp_shutdown_status_regs_tb;
  localparam int unsigned LOC = 20;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        pin     = 1'b0;
  logic        oc      = 1'b0;
  logic        per     = 1'b0;
  logic        wr      = 1'b0;
  logic        lit     = 1'b1;
  logic [2:0]  sel     = 3'h0;
  logic [7:0]  wd      = 8'h0;
  logic        fb;
  logic        run;
  logic [7:0]  rd;
  logic [2:0]  mode;
  logic [1:0]  st;
  logic [31:0] seed    = 32'h1f12ae6b;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cyc = 0;
  int          acc = 0;
  int          e0  = 1;
  always #5 clk_sys = ~clk_sys;
  lamp_shutdown_status_regs #(.LAMP_OUT_CYCLES(LOC)) dut (
    .clk_sys(clk_sys), .reset(reset), .shutdown_suspend_pin(pin),
    .lamp_current_feedback(fb), .overcurrent(oc), .pwm_period_start(per),
    .reg_wr(wr), .reg_sel(sel), .reg_wdata(wd), .reg_rdata(rd),
    .lamp_run(run), .shutdown_mode_field(mode), .lamp_fault_status(st));
  lamp_stage_model lamp (.clk_sys(clk_sys), .reset(reset), .lamp_run(run),
    .connected(lit), .lamp_current_feedback(fb));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrt(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    wr  <= 1'b1;
    sel <= s;
    wd  <= d;
    @(posedge clk_sys);
    wr  <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] s, input logic [7:0] exp);
    @(posedge clk_sys);
    sel <= s;
    @(posedge clk_sys);
    #1 chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    tick(20);
    reset <= 1'b0;
    tick(5);
    #1 chk({5'h0, mode}, 8'h01);
    chk({7'h0, run}, 8'h00);
    for (int i = 1; i < 8; i++) wrt(i[2:0], 8'hff);
    #1 chk({6'h0, st}, 8'h03);
    rdc(`REG_SEL_MAKER, `MAKER_CODE);
    rdc(`REG_SEL_PART, `PART_CODE);
    rdc(`REG_SEL_REVISION, `REVISION_CODE);
    rdc(3'h6, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 8; m++) begin
        @(posedge clk_sys);
        pin <= p[0];
        wrt(3'h0, m[7:0]);
        tick(6);
        #1 chk({7'h0, run}, {7'h0, !(m[2] || m[p])});
      end
    end
    for (int r = 0; r < 2; r++) begin
      lit <= 1'b0;
      wrt(3'h0, 8'h00);
      tick(LOC + 10);
      #1 chk({6'h0, st}, 8'h01);
      chk({7'h0, run}, 8'h00);
      lit <= 1'b1;
      tick(10);
      #1 chk({6'h0, st}, 8'h01);
      if (r == 0) begin
        wrt(3'h0, 8'h04);
      end else begin
        @(posedge clk_sys);
        pin <= ~pin;
      end
      tick(6);
      #1 chk({6'h0, st}, 8'h03);
    end
    for (int k = 0; k < 200; k++) begin
      seed = xs(seed);
      @(posedge clk_sys);
      oc  <= (seed[3:0] == 4'h0);
      per <= (k % 8 == 7);
      @(negedge clk_sys);
      chk({7'h0, st[0]}, {7'h0, e0[0]});
      acc = acc | (seed[3:0] == 4'h0);
      if (k % 8 == 7) begin
        e0  = !acc;
        acc = 0;
      end
    end
    report_and_stop;
  end
endmodule
